// File: rtl/psr_pkg.sv
package psr_pkg;

  // ****************************************
  // Register select codes
  // ****************************************
  localparam logic [1:0]  SEL_REFRESH = 2'h0;
  localparam logic [1:0]  SEL_IDENT   = 2'h1;
  localparam logic [1:0]  SEL_BURST   = 2'h2;
  localparam logic [1:0]  SEL_RSVD    = 2'h3;
  localparam int          SEL_HI      = 19;
  localparam int          SEL_LO      = 18;
  // Software sequence third-cycle data values
  localparam logic [15:0] SW_SEL_REFRESH = 16'h0000;
  localparam logic [15:0] SW_SEL_BURST   = 16'h0001;
  localparam logic [15:0] SW_SEL_IDENT   = 16'h0002;

  // ****************************************
  // Burst configuration fields
  // ****************************************
  localparam int          BC_OPMODE   = 15;
  localparam int          BC_FIXED    = 14;
  localparam int          BC_LAT_HI   = 13;
  localparam int          BC_LAT_LO   = 11;
  localparam int          BC_WAIT_POL = 10;
  localparam int          BC_WAIT_CFG = 8;
  localparam int          BC_DRIVE_LO = 4;
  localparam logic [15:0] BC_RESET    = 16'h1d1f;
  localparam logic [2:0]  LAT_DEFAULT = 3'h3;

  // ****************************************
  // Refresh configuration fields
  // ****************************************
  localparam int          RC_PAGE     = 7;
  localparam int          RC_DPD      = 4;
  localparam int          RC_PAR_HI   = 2;
  localparam logic [21:0] RC_RESET    = 22'h000010;
  localparam logic [2:0]  PAR_NONE    = 3'h4;
  localparam logic [21:0] ARRAY_TOP   = 22'h3fffff;
  // Idle bus levels, so no false pin edge follows reset
  localparam logic [44:0] PIN_IDLE    = {7'h2e, 22'h000000, 16'h0000};

  // ****************************************
  // Timing
  // ****************************************
  localparam int          CLK_PERIOD_NS   = 8;
  localparam int          INIT_TIME_US    = 150;
  localparam int          INIT_CYCLES_DEF = (INIT_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage : psr_pkg

// File: rtl/psr_config_regs.sv
`timescale 1ns/1ps
// Functional notes
// - Burst config bit 10 picks WAIT asserted level; resets active-high.
// - Bits 13:11 give latency clocks to first data; default code 3.
// - Variable latency accepts codes 2..4; refresh collision doubles the latency.
// - Variable mode delays data on collision and flags it on WAIT.
// - Fixed mode: constant latency equal to code 2..6; others reserved.
// - Data transfers on the clock following the counted latency cycles.
// - Bit 15 selects synchronous burst or asynchronous operation.
// - Refresh register powers up as 0010h.
// - Refresh register via enable pin select 00 or software data 0000h.
// - Refresh bit 7 enables page mode; cleared at power-up.
// - Bits 2:0 choose full, bottom, none or top refresh partition.
// - Bottom partitions start at zero, top ones end at 3FFFFFh.
// - Power-down bit zero then chip enable high enters deep power-down.
// - Chip enable low leaves deep power-down and sets bit 4 again.
// - After leaving power-down a 150us initialization runs before burst accesses.
// - Deep power-down stops all refresh activity.
// - Registers survive deep power-down except burst config bit 4 and refresh bit 4.
// - Bit 8 moves WAIT change one clock ahead of data.
module psr_config_regs
  import psr_pkg::*;
#(
  parameter int unsigned INIT_CYCLES  = INIT_CYCLES_DEF,
  // Arbitrary identification value
  parameter logic [15:0] DEVICE_ID    = 16'h5a21,
  parameter logic        OPMODE_RESET = 1'b1
) (
  // System
  input  wire logic        clk_in,
  input  wire logic        reset_in,
  input  wire logic        clk_en_in,
  // Memory pins
  input  wire logic        link_clk_in,
  input  wire logic        ce_n_in,
  input  wire logic        config_reg_enable_in,
  input  wire logic        we_n_in,
  input  wire logic        oe_n_in,
  input  wire logic        adv_n_in,
  input  wire logic        sw_seq_in,
  input  wire logic [21:0] addr_in,
  input  wire logic [15:0] dq_in,
  output logic      [15:0] dq_out,
  output logic             dq_oe_out,
  output logic             wait_out,
  // Refresh engine
  input  wire logic        refresh_collision_in,
  output logic             refresh_en_out,
  output logic             refresh_none_out,
  output logic      [21:0] refresh_lo_out,
  output logic      [21:0] refresh_hi_out,
  // Status and configuration
  output logic             data_valid_out,
  output logic             deep_powerdown_out,
  output logic             init_busy_out,
  output logic             page_mode_out,
  output logic      [15:0] burst_config_reg_out
);

  // ****************************************
  // Elaboration checks
  // ****************************************
  if (INIT_CYCLES == 0 || INIT_CYCLES >= 32768) begin : g_bad_init
    $error("INIT_CYCLES out of range");
  end

  // ****************************************
  // Functions
  // ****************************************
  function automatic logic [3:0] lat_clocks(input logic [2:0] code, input logic fixed, input logic coll);
    logic [2:0] c;
    c = code;
    if (fixed) begin
      if (code < 3'h2 || code > 3'h6) c = LAT_DEFAULT;
      return {1'b0, c};
    end
    if (code < 3'h2 || code > 3'h4) c = LAT_DEFAULT;
    return coll ? {c, 1'b0} : {1'b0, c};
  endfunction : lat_clocks

  function automatic logic [44:0] par_bounds(input logic [2:0] par);
    logic [21:0] span;
    span = ARRAY_TOP >> par[1:0];
    if (par == PAR_NONE) return {1'b1, 22'h0, 22'h0};
    if (!par[2] || par[1:0] == 2'h0) return {1'b0, 22'h0, span};
    return {1'b0, 22'(ARRAY_TOP - span), ARRAY_TOP};
  endfunction : par_bounds

  // ****************************************
  // Pin synchronisers
  // ****************************************
  localparam int PW = 45;
  logic [PW-1:0] pin_meta;
  logic [PW-1:0] pin_sync;
  logic          lclk_prev;
  logic          ce_n_prev;
  logic          we_n_prev;

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      pin_meta  <= PIN_IDLE;
      pin_sync  <= PIN_IDLE;
      lclk_prev <= 1'b0;
      ce_n_prev <= 1'b1;
      we_n_prev <= 1'b1;
    end else if (clk_en_in) begin
      pin_meta  <= {link_clk_in, ce_n_in, config_reg_enable_in, we_n_in, oe_n_in, adv_n_in, sw_seq_in,
                    addr_in, dq_in};
      pin_sync  <= pin_meta;
      lclk_prev <= pin_sync[44];
      ce_n_prev <= pin_sync[43];
      we_n_prev <= pin_sync[41];
    end
  end

  wire        s_lclk = pin_sync[44];
  wire        s_ce_n = pin_sync[43];
  wire        s_cre  = pin_sync[42];
  wire        s_we_n = pin_sync[41];
  wire        s_oe_n = pin_sync[40];
  wire        s_adv_n = pin_sync[39];
  wire        s_sw   = pin_sync[38];
  wire [21:0] s_addr = pin_sync[37:16];
  wire [15:0] s_dq   = pin_sync[15:0];
  wire        lclk_rise = s_lclk & ~lclk_prev;
  wire        ce_rise   = s_ce_n & ~ce_n_prev;
  wire        ce_fall   = ~s_ce_n & ce_n_prev;
  wire        we_rise   = s_we_n & ~we_n_prev;

  // ****************************************
  // Configuration access decode
  // ****************************************
  logic [15:0] burst_config_reg;
  logic        rc_page;
  logic        rc_dpd;
  logic [2:0]  rc_par;
  logic        sw_phase;
  logic [1:0]  sw_sel;
  logic        dpd_active;
  logic [14:0] init_cnt;

  wire [1:0]  sw_dec  = (s_dq == SW_SEL_REFRESH) ? SEL_REFRESH :
                        (s_dq == SW_SEL_BURST)   ? SEL_BURST   :
                        (s_dq == SW_SEL_IDENT)   ? SEL_IDENT   : SEL_RSVD;
  wire        sw_wr   = we_rise & ~s_ce_n & ~s_cre & s_sw;
  wire        wr_fire = we_rise & ~s_ce_n & (s_cre | (s_sw & sw_phase));
  wire [1:0]  wr_sel  = s_cre ? s_addr[SEL_HI:SEL_LO] : sw_sel;
  wire [21:0] wr_data = s_cre ? s_addr : {6'h00, s_dq};
  wire        wr_bcr  = wr_fire & (wr_sel == SEL_BURST);
  wire        wr_rcr  = wr_fire & (wr_sel == SEL_REFRESH);
  wire        rd_sel_ok = s_cre | (s_sw & sw_phase);
  wire [1:0]  rd_sel  = s_cre ? s_addr[SEL_HI:SEL_LO] : sw_sel;
  // Reserved and ignored bits read zero
  wire [15:0] rcr_word = {8'h00, rc_page, 2'h0, rc_dpd, 1'b0, rc_par};
  wire [15:0] rd_word  = (rd_sel == SEL_BURST)   ? burst_config_reg :
                         (rd_sel == SEL_REFRESH) ? rcr_word :
                         (rd_sel == SEL_IDENT)   ? DEVICE_ID : 16'h0000;
  wire        rd_en   = ~s_oe_n & ~s_ce_n & s_we_n & rd_sel_ok;

  wire        dpd_enter = ce_rise & ~rc_dpd & ~dpd_active;
  wire        dpd_exit  = ce_fall & dpd_active;

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      sw_phase <= 1'b0;
      sw_sel   <= SEL_RSVD;
    end else if (clk_en_in) begin
      if (!s_sw) begin
        sw_phase <= 1'b0;
      end else if (sw_wr) begin
        sw_phase <= ~sw_phase;
        if (!sw_phase) sw_sel <= sw_dec;
      end
    end
  end

  // ****************************************
  // Configuration registers
  // ****************************************
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      burst_config_reg <= {OPMODE_RESET, BC_RESET[14:0]};
      rc_page <= RC_RESET[RC_PAGE];
      rc_dpd  <= RC_RESET[RC_DPD];
      rc_par  <= RC_RESET[RC_PAR_HI:0];
    end else if (clk_en_in) begin
      if (wr_bcr) burst_config_reg <= wr_data[15:0];
      if (dpd_enter) burst_config_reg[BC_DRIVE_LO] <= BC_RESET[BC_DRIVE_LO];
      if (wr_rcr) begin
        rc_page <= wr_data[RC_PAGE];
        rc_dpd  <= wr_data[RC_DPD];
        rc_par  <= wr_data[RC_PAR_HI:0];
      end
      if (dpd_exit) rc_dpd <= 1'b1;
    end
  end

  // ****************************************
  // Deep power-down and initialization
  // ****************************************
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      dpd_active <= 1'b0;
      init_cnt   <= 15'h0000;
    end else if (clk_en_in) begin
      if (dpd_enter) dpd_active <= 1'b1;
      else if (dpd_exit) dpd_active <= 1'b0;
      if (dpd_exit) init_cnt <= 15'(INIT_CYCLES);
      else if (init_cnt != 15'h0000) init_cnt <= init_cnt - 15'h0001;
    end
  end

  // ****************************************
  // Burst latency and WAIT
  // ****************************************
  logic       burst_on;
  logic       wait_act;
  logic       dvalid;
  logic [3:0] lat_cnt;
  logic [3:0] lat_q;
  logic [3:0] edge_cnt;

  wire        sync_mode = ~burst_config_reg[BC_OPMODE];
  wire        fixed_lat = burst_config_reg[BC_FIXED];
  wire        early_wait = burst_config_reg[BC_WAIT_CFG];
  wire        start = lclk_rise & ~s_adv_n & ~s_ce_n & ~s_cre & sync_mode & ~dpd_active & (init_cnt == 15'h0000);
  wire [3:0]  lat_sel = lat_clocks(burst_config_reg[BC_LAT_HI:BC_LAT_LO], fixed_lat, refresh_collision_in);
  wire        lat_step = lclk_rise & burst_on & ~dvalid & ~start;
  wire        wait_drop = lat_step & ((lat_cnt == 4'h1) | (early_wait & (lat_cnt == 4'h2)));

  logic next_wait_act;
  always_comb begin
    next_wait_act = wait_act;
    if (s_ce_n) next_wait_act = 1'b0;
    else if (start) next_wait_act = 1'b1;
    else if (wait_drop) next_wait_act = 1'b0;
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      burst_on <= 1'b0;
      wait_act <= 1'b0;
      dvalid   <= 1'b0;
      lat_cnt  <= 4'h0;
      lat_q    <= 4'h0;
      edge_cnt <= 4'h0;
    end else if (clk_en_in) begin
      wait_act <= next_wait_act;
      if (s_ce_n) begin
        burst_on <= 1'b0;
        dvalid   <= 1'b0;
      end else if (start) begin
        burst_on <= 1'b1;
        dvalid   <= 1'b0;
        lat_cnt  <= lat_sel;
        lat_q    <= lat_sel;
        edge_cnt <= 4'h0;
      end else if (lat_step) begin
        lat_cnt  <= lat_cnt - 4'h1;
        edge_cnt <= edge_cnt + 4'h1;
        if (lat_cnt == 4'h1) dvalid <= 1'b1;
      end
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  wire [44:0] bounds = par_bounds(rc_par);

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      wait_out             <= 1'b0;
      dq_out               <= 16'h0000;
      dq_oe_out            <= 1'b0;
      refresh_en_out       <= 1'b1;
      refresh_none_out     <= 1'b0;
      refresh_lo_out       <= 22'h000000;
      refresh_hi_out       <= ARRAY_TOP;
      data_valid_out       <= 1'b0;
      deep_powerdown_out   <= 1'b0;
      init_busy_out        <= 1'b0;
      page_mode_out        <= 1'b0;
      burst_config_reg_out <= BC_RESET;
    end else if (clk_en_in) begin
      wait_out             <= ~(next_wait_act ^ burst_config_reg[BC_WAIT_POL]);
      dq_out               <= rd_en ? rd_word : 16'h0000;
      dq_oe_out            <= rd_en;
      refresh_en_out       <= ~dpd_active & ~bounds[44];
      refresh_none_out     <= bounds[44];
      refresh_lo_out       <= bounds[43:22];
      refresh_hi_out       <= bounds[21:0];
      data_valid_out       <= dvalid;
      deep_powerdown_out   <= dpd_active;
      init_busy_out        <= (init_cnt != 15'h0000);
      page_mode_out        <= rc_page;
      burst_config_reg_out <= burst_config_reg;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  // A burst start raises WAIT at once, so idle is judged on the next value
  AST_WAIT_IDLE: assert property (@(posedge clk_in) disable iff (reset_in)
    clk_en_in && !next_wait_act |=> wait_out == ~$past(burst_config_reg[BC_WAIT_POL]))
    else $error("WAIT idle level does not follow polarity");
  AST_RCR_RESET: assert property (@(posedge clk_in)
    $past(reset_in) && !reset_in |-> rcr_word == RC_RESET[15:0] && !rc_page)
    else $error("Refresh register reset value wrong");
  AST_DPD_EXIT: assert property (@(posedge clk_in) disable iff (reset_in)
    clk_en_in && dpd_exit |=> !dpd_active && rc_dpd && init_cnt == 15'(INIT_CYCLES))
    else $error("Deep power-down exit incomplete");
  AST_INIT_BUSY: assert property (@(posedge clk_in) disable iff (reset_in)
    clk_en_in && dpd_exit |=> ##1 init_busy_out)
    else $error("Initialization busy not shown");
  AST_REFRESH_OFF: assert property (@(posedge clk_in) disable iff (reset_in)
    dpd_active && $past(dpd_active) && clk_en_in && $past(clk_en_in) |-> !refresh_en_out)
    else $error("Refresh running in deep power-down");
  AST_RSVD_SEL: assert property (@(posedge clk_in) disable iff (reset_in)
    clk_en_in && wr_fire && wr_sel == SEL_RSVD && !dpd_enter && !dpd_exit |=> $stable(burst_config_reg) && $stable(rcr_word))
    else $error("Reserved select changed a register");
  AST_BCR4_DPD: assert property (@(posedge clk_in) disable iff (reset_in)
    clk_en_in && dpd_enter && !wr_bcr |=> burst_config_reg[BC_DRIVE_LO] == BC_RESET[BC_DRIVE_LO] && dpd_active)
    else $error("Power-down entry mishandled");
  AST_LAT_COUNT: assert property (@(posedge clk_in) disable iff (reset_in)
    $rose(dvalid) |-> edge_cnt == lat_q && !s_ce_n)
    else $error("Data valid at wrong latency");
  AST_FIXED_LAT: assert property (@(posedge clk_in) disable iff (reset_in)
    clk_en_in && start && fixed_lat && burst_config_reg[13:11] >= 3'h2 && burst_config_reg[13:11] <= 3'h6
      |=> lat_q == {1'b0, $past(burst_config_reg[13:11])})
    else $error("Fixed latency not equal to code");
  AST_VAR_COLL: assert property (@(posedge clk_in) disable iff (reset_in)
    clk_en_in && start && !fixed_lat && refresh_collision_in && burst_config_reg[13:11] == 3'h4 |=> lat_q == 4'h8)
    else $error("Collision latency not doubled");

endmodule : psr_config_regs

// File: tb/psr_ctrl_model.sv
`timescale 1ns/1ps
module psr_ctrl_model
  import psr_pkg::*;
#(
  parameter int INIT_WAIT = 24
) (
  // Clock
  input  wire logic        clk_in,
  // Pins toward the device
  output logic             link_clk_out,
  output logic             ce_n_out,
  output logic             cre_out,
  output logic             we_n_out,
  output logic             oe_n_out,
  output logic             adv_n_out,
  output logic             sw_seq_out,
  output logic      [21:0] addr_out,
  output logic      [15:0] dq_out,
  // Pins from the device
  input  wire logic        wait_in,
  input  wire logic        data_valid_in,
  input  wire logic        dq_oe_in,
  input  wire logic        init_busy_in,
  input  wire logic [15:0] dq_in
);
  // ****************************************
  // Controller transfers
  // ****************************************
  initial begin
    link_clk_out = 1'b0;
    ce_n_out     = 1'b1;
    cre_out      = 1'b0;
    we_n_out     = 1'b1;
    oe_n_out     = 1'b1;
    adv_n_out    = 1'b1;
    sw_seq_out   = 1'b0;
    addr_out     = 22'h155555;
    dq_out       = 16'h5555;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask : tick

  // Four clocks each phase, above the synchroniser depth
  task automatic strobe();
    we_n_out <= 1'b0;
    tick(4);
    we_n_out <= 1'b1;
    tick(4);
  endtask : strobe

  task automatic cfg_write(input logic [1:0] sel, input logic [21:0] data);
    logic [21:0] word;
    word = (sel == SEL_REFRESH) ? (data & 22'h0000f7) : data;
    ce_n_out <= 1'b0;
    cre_out  <= 1'b1;
    addr_out <= {word[21:20], sel, word[17:0]};
    tick(4);
    strobe();
    ce_n_out <= 1'b1;
    cre_out  <= 1'b0;
    addr_out <= ~addr_out;
    tick(4);
  endtask : cfg_write

  task automatic cfg_read(input logic [1:0] sel, output logic [15:0] val);
    ce_n_out <= 1'b0;
    cre_out  <= 1'b1;
    oe_n_out <= 1'b0;
    addr_out <= {2'h0, sel, 18'h0};
    tick(8);
    val = dq_oe_in ? dq_in : 16'hxxxx;
    ce_n_out <= 1'b1;
    cre_out  <= 1'b0;
    oe_n_out <= 1'b1;
    addr_out <= ~addr_out;
    tick(4);
  endtask : cfg_read

  task automatic sw_write(input logic [15:0] selw, input logic [15:0] data);
    sw_seq_out <= 1'b1;
    ce_n_out   <= 1'b0;
    dq_out     <= selw;
    tick(4);
    strobe();
    dq_out <= data;
    tick(2);
    strobe();
    sw_seq_out <= 1'b0;
    ce_n_out   <= 1'b1;
    dq_out     <= ~dq_out;
    tick(4);
  endtask : sw_write

  // Link clock runs only inside the frame
  task automatic burst(input logic wait_act, output int lat, output int wk);
    lat = 15;
    wk  = 15;
    ce_n_out  <= 1'b0;
    adv_n_out <= 1'b0;
    tick(4);
    for (int k = 0; k < 10; k++) begin
      link_clk_out <= 1'b1;
      tick(10);
      if (wk == 15 && wait_in !== wait_act) wk = k;
      if (lat == 15 && data_valid_in === 1'b1) lat = k;
      link_clk_out <= 1'b0;
      adv_n_out    <= 1'b1;
      tick(10);
    end
    ce_n_out <= 1'b1;
    tick(6);
  endtask : burst

  task automatic wake(output logic busy);
    ce_n_out <= 1'b0;
    tick(6);
    busy = init_busy_in;
    tick(INIT_WAIT);
    ce_n_out <= 1'b1;
    tick(4);
  endtask : wake
endmodule : psr_ctrl_model

// File: tb/psr_config_regs_tb.sv
`timescale 1ns/1ps
module psr_config_regs_tb;
  import psr_pkg::*;
  localparam int INIT_N = 20;
  logic        clk_in, reset_in, collision, link_clk, ce_n, config_reg_enable, we_n, oe_n, adv_n, sw_seq;
  logic        dq_oe, wait_w, ref_en, ref_none, dvalid, deep_powerdown, init_busy, page;
  logic [21:0] addr, ref_lo, ref_hi;
  logic [15:0] dq_w, dq_rd, burst_cfg;
  int          n_mismatch, cmp_count, cycles;

  // Identification value is arbitrary
  psr_config_regs #(.INIT_CYCLES(INIT_N), .DEVICE_ID(16'h3c5a), .OPMODE_RESET(1'b1)) psr_config_regs_i (
    .clk_in(clk_in), .reset_in(reset_in), .clk_en_in(1'b1), .link_clk_in(link_clk), .ce_n_in(ce_n),
    .config_reg_enable_in(config_reg_enable), .we_n_in(we_n), .oe_n_in(oe_n), .adv_n_in(adv_n), .sw_seq_in(sw_seq),
    .addr_in(addr), .dq_in(dq_w), .dq_out(dq_rd), .dq_oe_out(dq_oe), .wait_out(wait_w),
    .refresh_collision_in(collision), .refresh_en_out(ref_en), .refresh_none_out(ref_none),
    .refresh_lo_out(ref_lo), .refresh_hi_out(ref_hi), .data_valid_out(dvalid), .deep_powerdown_out(deep_powerdown),
    .init_busy_out(init_busy), .page_mode_out(page), .burst_config_reg_out(burst_cfg));

  psr_ctrl_model #(.INIT_WAIT(INIT_N + 4)) psr_ctrl_model_i (
    .clk_in(clk_in), .link_clk_out(link_clk), .ce_n_out(ce_n), .cre_out(config_reg_enable), .we_n_out(we_n),
    .oe_n_out(oe_n), .adv_n_out(adv_n), .sw_seq_out(sw_seq), .addr_out(addr), .dq_out(dq_w),
    .wait_in(wait_w), .data_valid_in(dvalid), .dq_oe_in(dq_oe), .init_busy_in(init_busy), .dq_in(dq_rd));

  // ****************************************
  // Checks and scenarios
  // ****************************************
  initial clk_in = 1'b0;
  always #4 clk_in = ~clk_in;

  task automatic results();
    $display("Comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : results

  // Hang guard, far above the expected run length
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      n_mismatch++;
      results();
    end
  end

  task automatic chk(input logic [21:0] got, input logic [21:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic t_reset();
    logic [15:0] v;
    psr_ctrl_model_i.cfg_read(SEL_REFRESH, v);
    chk(22'(v), 22'h000010);
    chk(22'(burst_cfg), 22'h009d1f);
    chk(22'(wait_w), 22'h0);
    chk(22'(page), 22'h0);
    chk(ref_hi, ARRAY_TOP);
  endtask : t_reset

  task automatic t_partition();
    logic [15:0] v;
    logic [21:0] lo_e [8] = '{22'h000000, 22'h000000, 22'h000000, 22'h000000,
                              22'h000000, 22'h200000, 22'h300000, 22'h380000};
    logic [21:0] hi_e [8] = '{22'h3fffff, 22'h1fffff, 22'h0fffff, 22'h07ffff,
                              22'h000000, 22'h3fffff, 22'h3fffff, 22'h3fffff};
    for (int c = 0; c < 8; c++) begin
      psr_ctrl_model_i.cfg_write(SEL_REFRESH, 22'h000070 | 22'(c));
      chk(22'(ref_none), 22'(c == 4));
      if (c != 4) begin
        chk(ref_lo, lo_e[c]);
        chk(ref_hi, hi_e[c]);
      end else begin
        chk(22'(ref_en), 22'h0);
      end
    end
    psr_ctrl_model_i.cfg_read(SEL_REFRESH, v);
    chk(22'(v), 22'h000017);
    psr_ctrl_model_i.cfg_write(SEL_RSVD, 22'h0000ff);
    psr_ctrl_model_i.cfg_write(SEL_IDENT, 22'h000000);
    psr_ctrl_model_i.cfg_read(SEL_REFRESH, v);
    chk(22'(v), 22'h000017);
    chk(22'(burst_cfg), 22'h009d1f);
    psr_ctrl_model_i.cfg_read(SEL_IDENT, v);
    chk(22'(v), 22'h003c5a);
  endtask : t_partition

  task automatic t_sw();
    logic [15:0] v;
    psr_ctrl_model_i.sw_write(SW_SEL_REFRESH, 16'h0013);
    psr_ctrl_model_i.cfg_read(SEL_REFRESH, v);
    chk(22'(v), 22'h000013);
    psr_ctrl_model_i.sw_write(SW_SEL_BURST, 16'h2d1f);
    chk(22'(burst_cfg), 22'h002d1f);
  endtask : t_sw

  task automatic t_burst();
    // Fixed codes 6 and 2 chosen for the link clock
    logic [15:0] cfg [7] = '{16'h9d1f, 16'h141f, 16'h211f, 16'h741f, 16'h551f, 16'h341f, 16'h1c1f};
    logic        col [7] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
    int          exp_l [7] = '{15, 2, 8, 6, 2, 3, 6};
    int          exp_w [7] = '{0, 2, 7, 6, 1, 3, 6};
    int          lat, wk;
    for (int i = 0; i < 7; i++) begin
      psr_ctrl_model_i.cfg_write(SEL_BURST, {6'h0, cfg[i]});
      chk(22'(burst_cfg), {6'h0, cfg[i]});
      @(posedge clk_in);
      collision <= col[i];
      psr_ctrl_model_i.burst(cfg[i][BC_WAIT_POL], lat, wk);
      chk(22'(lat), 22'(exp_l[i]));
      chk(22'(wk), 22'(exp_w[i]));
    end
    collision <= 1'b0;
  endtask : t_burst

  task automatic t_dpd();
    logic [15:0] v;
    logic        busy;
    psr_ctrl_model_i.cfg_write(SEL_BURST, 22'h001d0f);
    psr_ctrl_model_i.cfg_write(SEL_REFRESH, 22'h000083);
    // Entry shows only after the released chip enable is synced
    repeat (2) @(posedge clk_in);
    chk(22'(deep_powerdown), 22'h1);
    chk(22'(ref_en), 22'h0);
    psr_ctrl_model_i.wake(busy);
    chk(22'(busy), 22'h1);
    chk(22'(deep_powerdown), 22'h0);
    chk(22'(init_busy), 22'h0);
    psr_ctrl_model_i.cfg_read(SEL_REFRESH, v);
    chk(22'(v), 22'h000093);
    chk(22'(burst_cfg), 22'h001d1f);
    chk(22'(page), 22'h1);
  endtask : t_dpd

  initial begin
    reset_in   = 1'b1;
    collision  = 1'b0;
    n_mismatch = 0;
    cmp_count  = 0;
    repeat (4) @(posedge clk_in);
    reset_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    t_reset();
    t_partition();
    t_sw();
    t_burst();
    t_dpd();
    results();
  end
endmodule : psr_config_regs_tb
